//--- core/gpport_top.sv
// two gpio ports: an eight-pin port and a two-pin port with peripheral sharing
// assumes: axi4-lite master on clk_i; pins asynchronous; peripherals on clk_i
//
// How it works
// - eight-pin port, per-pin input or output
// - two-pin port, per-pin direction, timer sharing
// - eight-pin port carries interrupt, divider, timer functions
// - eight-pin latch resets zero, drives level
// - eight-pin direction resets input, one means output
// - input pins feed interrupt and timer inputs
// - eight-pin select implements bits four to zero
// - select plus output drives peripheral outputs
// - eight-pin read: live pin if input, else zero
// - two-pin latch bits one and zero only
// - two-pin direction resets input, feeds timer inputs
// - two-pin select picks timer or latch outputs
// - two-pin read: pin if input, upper zero
`timescale 1ns/100ps
`include "gpport_map.svh"
module gpport_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // axi4-lite write address and data
  input  wire logic [13:0] awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  // axi4-lite write response
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  // axi4-lite read
  input  wire logic [13:0] araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // eight-pin port pins
  input  wire logic [7:0]  port7_pin_i,
  output logic [7:0]       port7_pin_o,
  output logic [7:0]       port7_pin_oe_o,
  // two-pin port pins
  input  wire logic [1:0]  port8_pin_i,
  output logic [1:0]       port8_pin_o,
  output logic [1:0]       port8_pin_oe_o,
  // peripheral outputs routed to the pins
  input  wire logic        divider_out_i,
  input  wire logic        pulse_gen_a_out_1_i,
  input  wire logic        pulse_gen_a_out_0_i,
  input  wire logic        timer_out_01_i,
  input  wire logic        timer_out_00_i,
  input  wire logic        timer_out_03_i,
  input  wire logic        timer_out_02_i,
  // peripheral inputs taken from the pins
  output logic             ext_irq_line_four_o,
  output logic             ext_irq_line_three_o,
  output logic             ext_irq_line_two_o,
  output logic             timer_a_in_1_o,
  output logic             timer_a_in_0_o,
  output logic             timer_in_01_o,
  output logic             timer_in_00_o,
  output logic             timer_in_03_o,
  output logic             timer_in_02_o
);

  // ****************************************
  // register bus slave
  // ****************************************
  gpport_reg_if regs ();

  gpport_axil_slave u_slave (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .awaddr_i  (awaddr_i),
    .awvalid_i (awvalid_i),
    .awready_o (awready_o),
    .wdata_i   (wdata_i),
    .wstrb_i   (wstrb_i),
    .wvalid_i  (wvalid_i),
    .wready_o  (wready_o),
    .bresp_o   (bresp_o),
    .bvalid_o  (bvalid_o),
    .bready_i  (bready_i),
    .araddr_i  (araddr_i),
    .arvalid_i (arvalid_i),
    .arready_o (arready_o),
    .rdata_o   (rdata_o),
    .rresp_o   (rresp_o),
    .rvalid_o  (rvalid_o),
    .rready_i  (rready_i),
    .regs      (regs)
  );

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0] port7_output_latch;
  logic [7:0] port7_direction;
  logic [4:0] port7_function_select;
  logic [1:0] port8_output_latch;
  logic [1:0] port8_direction;
  logic [1:0] port8_function_select;

  function automatic logic wr_hit(input gpport_pkg::gpport_reg_t which);
    wr_hit = regs.wr_en && (regs.wr_reg == which);
  endfunction

  // only implemented bits are stored; the rest are simply not kept
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port7_output_latch    <= `GPP_RESET_VALUE;
      port7_direction       <= `GPP_RESET_VALUE;
      port7_function_select <= 5'(`GPP_RESET_VALUE);
      port8_output_latch    <= 2'(`GPP_RESET_VALUE);
      port8_direction       <= 2'(`GPP_RESET_VALUE);
      port8_function_select <= 2'(`GPP_RESET_VALUE);
    end else begin
      if (wr_hit(gpport_pkg::GPP_REG_P7_LATCH)) begin
        port7_output_latch <= regs.wr_data & `GPP_P7_MASK;
      end
      if (wr_hit(gpport_pkg::GPP_REG_P7_DIR)) begin
        port7_direction <= regs.wr_data & `GPP_P7_MASK;
      end
      if (wr_hit(gpport_pkg::GPP_REG_P7_FSEL)) begin
        port7_function_select <= regs.wr_data[4:0];
      end
      if (wr_hit(gpport_pkg::GPP_REG_P8_LATCH)) begin
        port8_output_latch <= regs.wr_data[1:0];
      end
      if (wr_hit(gpport_pkg::GPP_REG_P8_DIR)) begin
        port8_direction <= regs.wr_data[1:0];
      end
      if (wr_hit(gpport_pkg::GPP_REG_P8_FSEL)) begin
        port8_function_select <= regs.wr_data[1:0];
      end
    end
  end

  // ****************************************
  // pin input synchronisers
  // ****************************************
  logic [9:0] pin_meta;
  logic [9:0] pin_sync;

  // second stage is the only reader of the first
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_meta <= 10'h000;
      pin_sync <= 10'h000;
    end else begin
      pin_meta <= {port8_pin_i, port7_pin_i};
      pin_sync <= pin_meta;
    end
  end

  wire [7:0] port7_level = pin_sync[7:0];
  wire [1:0] port8_level = pin_sync[9:8];

  // ****************************************
  // read data
  // ****************************************
  wire [7:0] port7_pin_input = port7_level & ~port7_direction;
  wire [1:0] port8_pin_input = port8_level & ~port8_direction;

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (regs.rd_reg)
      gpport_pkg::GPP_REG_P7_LATCH: rd_mux = port7_output_latch;
      gpport_pkg::GPP_REG_P8_LATCH: rd_mux = {6'h00, port8_output_latch};
      gpport_pkg::GPP_REG_P7_PIN:   rd_mux = port7_pin_input;
      gpport_pkg::GPP_REG_P8_PIN:   rd_mux = {6'h00, port8_pin_input};
      gpport_pkg::GPP_REG_P7_DIR:   rd_mux = port7_direction;
      gpport_pkg::GPP_REG_P8_DIR:   rd_mux = {6'h00, port8_direction};
      gpport_pkg::GPP_REG_P7_FSEL:  rd_mux = {3'h0, port7_function_select};
      gpport_pkg::GPP_REG_P8_FSEL:  rd_mux = {6'h00, port8_function_select};
    endcase
  end
  assign regs.rd_data = rd_mux;

  // ****************************************
  // pin drive and alternate-function routing
  // ****************************************
  // bits 7..5 have no alternate output and always drive from the latch
  wire [7:0] port7_alt   = {3'h0, divider_out_i, pulse_gen_a_out_1_i, pulse_gen_a_out_0_i,
                            timer_out_01_i, timer_out_00_i};
  wire [7:0] port7_fsel8 = {3'h0, port7_function_select};
  wire [7:0] next_port7_pin = (port7_fsel8 & port7_alt) | (~port7_fsel8 & port7_output_latch);
  wire [1:0] port8_alt   = {timer_out_03_i, timer_out_02_i};
  wire [1:0] next_port8_pin = (port8_function_select & port8_alt)
                            | (~port8_function_select & port8_output_latch);

  // inputs to peripherals are gated to zero when the pin is an output
  wire [7:0] next_port7_in = port7_level & ~port7_direction;
  wire [1:0] next_port8_in = port8_level & ~port8_direction;

  // registered outputs cost one cycle on each alternate path, in exchange for glitch-free pins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port7_pin_o          <= 8'h00;
      port7_pin_oe_o       <= 8'h00;
      port8_pin_o          <= 2'h0;
      port8_pin_oe_o       <= 2'h0;
      ext_irq_line_four_o  <= 1'b0;
      ext_irq_line_three_o <= 1'b0;
      ext_irq_line_two_o   <= 1'b0;
      timer_a_in_1_o       <= 1'b0;
      timer_a_in_0_o       <= 1'b0;
      timer_in_01_o        <= 1'b0;
      timer_in_00_o        <= 1'b0;
      timer_in_03_o        <= 1'b0;
      timer_in_02_o        <= 1'b0;
    end else begin
      port7_pin_o          <= next_port7_pin;
      port7_pin_oe_o       <= port7_direction;
      port8_pin_o          <= next_port8_pin;
      port8_pin_oe_o       <= port8_direction;
      ext_irq_line_four_o  <= next_port7_in[7];
      ext_irq_line_three_o <= next_port7_in[6];
      ext_irq_line_two_o   <= next_port7_in[5];
      timer_a_in_1_o       <= next_port7_in[3];
      timer_a_in_0_o       <= next_port7_in[2];
      timer_in_01_o        <= next_port7_in[1];
      timer_in_00_o        <= next_port7_in[0];
      timer_in_03_o        <= next_port8_in[1];
      timer_in_02_o        <= next_port8_in[0];
    end
  end

endmodule // gpport_top

//--- include/gpport_map.svh
// register offsets, field widths and reset values of the two gpio ports
// assumes: included by bare name from design and bench files
`ifndef GPPORT_MAP_SVH
`define GPPORT_MAP_SVH

// ****************************************
// register indices (not all multiples of four: byte address is index times four)
// ****************************************
`define GPP_IDX_P7_LATCH   12'h007
`define GPP_IDX_P8_LATCH   12'h008
`define GPP_IDX_P7_PIN     12'h014
`define GPP_IDX_P8_PIN     12'h015
`define GPP_IDX_P7_DIR     12'hf21
`define GPP_IDX_P8_DIR     12'hf22
`define GPP_IDX_P7_FSEL    12'hf3b
`define GPP_IDX_P8_FSEL    12'hf3c

// ****************************************
// implemented bit masks and reset values
// ****************************************
`define GPP_P7_MASK        8'hff
`define GPP_P7_FSEL_MASK   8'h1f
`define GPP_P8_MASK        8'h03
`define GPP_RESET_VALUE    8'h00

// ****************************************
// axi responses
// ****************************************
`define GPP_RESP_OKAY      2'b00
`define GPP_RESP_SLVERR    2'b10

`endif

//--- include/gpport_pkg.sv
// types shared by the gpio port top and its register slave
// assumes: compiled before any design file
package gpport_pkg;

  typedef enum logic [2:0] {
    GPP_REG_P7_LATCH = 3'd0,
    GPP_REG_P8_LATCH = 3'd1,
    GPP_REG_P7_PIN   = 3'd2,
    GPP_REG_P8_PIN   = 3'd3,
    GPP_REG_P7_DIR   = 3'd4,
    GPP_REG_P8_DIR   = 3'd5,
    GPP_REG_P7_FSEL  = 3'd6,
    GPP_REG_P8_FSEL  = 3'd7
  } gpport_reg_t;

  typedef logic [7:0] gpport_byte_t;

endpackage

//--- include/gpport_reg_if.sv
// carries decoded register writes and read data between slave and port core
// assumes: one clock domain, used only inside the gpio port block
`timescale 1ns/100ps
interface gpport_reg_if;
  logic                   wr_en;
  gpport_pkg::gpport_reg_t wr_reg;
  gpport_pkg::gpport_byte_t wr_data;
  gpport_pkg::gpport_reg_t rd_reg;
  gpport_pkg::gpport_byte_t rd_data;

  modport slave (output wr_en, output wr_reg, output wr_data, output rd_reg, input rd_data);
  modport core  (input wr_en, input wr_reg, input wr_data, input rd_reg, output rd_data);
endinterface

//--- core/gpport_axil_slave.sv
// axi4-lite slave that turns bus cycles into register writes and reads
// assumes: single clock, asynchronous active-low reset, one access of each kind at a time
`timescale 1ns/100ps
`include "gpport_map.svh"
module gpport_axil_slave (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // write address and data
  input  wire logic [13:0] awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  // write response
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  // read address and data
  input  wire logic [13:0] araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // register side
  gpport_reg_if.slave      regs
);

  // ****************************************
  // address decode
  // ****************************************
  // result is {hit, register code}; a plain return keeps it usable in continuous assignments
  function automatic logic [3:0] decode(input logic [13:0] addr);
    logic [11:0] idx;
    idx = addr[13:2];
    decode = 4'h0;
    unique case (idx)
      `GPP_IDX_P7_LATCH: decode = {1'b1, gpport_pkg::GPP_REG_P7_LATCH};
      `GPP_IDX_P8_LATCH: decode = {1'b1, gpport_pkg::GPP_REG_P8_LATCH};
      `GPP_IDX_P7_PIN:   decode = {1'b1, gpport_pkg::GPP_REG_P7_PIN};
      `GPP_IDX_P8_PIN:   decode = {1'b1, gpport_pkg::GPP_REG_P8_PIN};
      `GPP_IDX_P7_DIR:   decode = {1'b1, gpport_pkg::GPP_REG_P7_DIR};
      `GPP_IDX_P8_DIR:   decode = {1'b1, gpport_pkg::GPP_REG_P8_DIR};
      `GPP_IDX_P7_FSEL:  decode = {1'b1, gpport_pkg::GPP_REG_P7_FSEL};
      `GPP_IDX_P8_FSEL:  decode = {1'b1, gpport_pkg::GPP_REG_P8_FSEL};
      default:           decode = 4'h0;
    endcase
  endfunction

  // ****************************************
  // write path
  // ****************************************
  logic [13:0]              aw_addr;
  logic                     aw_held;
  logic [7:0]               w_data;
  logic                     w_lane0;
  logic                     w_held;
  gpport_pkg::gpport_reg_t  w_sel;
  logic                     w_hit;
  wire                      aw_take = awvalid_i && awready_o;
  wire                      w_take  = wvalid_i && wready_o;
  wire                      w_fire  = aw_held && w_held && !bvalid_o;

  wire [3:0]                w_dec = decode(aw_addr);
  assign w_hit         = w_dec[3];
  assign w_sel         = gpport_pkg::gpport_reg_t'(w_dec[2:0]);
  assign regs.wr_en    = w_fire && w_hit && w_lane0;
  assign regs.wr_reg   = w_sel;
  assign regs.wr_data  = w_data;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_addr   <= 14'h0000;
      aw_held   <= 1'b0;
      w_data    <= 8'h00;
      w_lane0   <= 1'b0;
      w_held    <= 1'b0;
      awready_o <= 1'b0;
      wready_o  <= 1'b0;
      bvalid_o  <= 1'b0;
      bresp_o   <= `GPP_RESP_OKAY;
    end else begin
      awready_o <= !aw_held && !aw_take && !bvalid_o;
      wready_o  <= !w_held && !w_take && !bvalid_o;
      if (aw_take) begin
        aw_addr <= awaddr_i;
        aw_held <= 1'b1;
      end
      if (w_take) begin
        w_data  <= wdata_i[7:0];
        w_lane0 <= wstrb_i[0];
        w_held  <= 1'b1;
      end
      if (w_fire) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o  <= w_hit ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
      end else if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  gpport_pkg::gpport_reg_t  r_sel;
  logic                     r_hit;
  wire                      ar_take = arvalid_i && arready_o;

  wire [3:0]                r_dec = decode(araddr_i);
  assign r_hit       = r_dec[3];
  assign r_sel       = gpport_pkg::gpport_reg_t'(r_dec[2:0]);
  assign regs.rd_reg = r_sel;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      arready_o <= 1'b0;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      rresp_o   <= `GPP_RESP_OKAY;
    end else begin
      arready_o <= !rvalid_o && !ar_take;
      if (ar_take) begin
        rvalid_o <= 1'b1;
        rdata_o  <= r_hit ? {24'h00_0000, regs.rd_data} : 32'h0000_0000;
        rresp_o  <= r_hit ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
      end else if (rvalid_o && rready_i) begin
        rvalid_o <= 1'b0;
      end
    end
  end

endmodule // gpport_axil_slave

//--- tb/gpport_assertions.sv
// concurrent checks on the gpio port top: bus answers and pin gating
// assumes: bound to gpport_top, one clock, reset active low
`timescale 1ns/100ps
`include "gpport_map.svh"
module gpport_assertions (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        resetn_i,
  // bus
  input wire logic        awvalid_i,
  input wire logic        awready_o,
  input wire logic        wvalid_i,
  input wire logic        wready_o,
  input wire logic [1:0]  bresp_o,
  input wire logic        bvalid_o,
  input wire logic        bready_i,
  input wire logic        arvalid_i,
  input wire logic        arready_o,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0]  rresp_o,
  input wire logic        rvalid_o,
  input wire logic        rready_i,
  // pins and peripheral inputs
  input wire logic [7:0]  port7_pin_i,
  input wire logic [7:0]  port7_pin_oe_o,
  input wire logic [1:0]  port8_pin_oe_o,
  input wire logic        ext_irq_line_four_o,
  input wire logic        timer_in_00_o,
  input wire logic        timer_in_02_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // synchronisers restart empty, so the edge that releases reset is no pin sample yet
  logic settled;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      settled <= 1'b0;
    end else begin
      settled <= 1'b1;
    end
  end

  sequence s_write_taken;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  sequence s_read_taken;
    arvalid_i && arready_o;
  endsequence

  a_write_answer: assert property (s_write_taken |=> ##1 bvalid_o)
    else $error("write response not two cycles after handshake");
  a_read_answer: assert property (s_read_taken |=> rvalid_o)
    else $error("read data not one cycle after handshake");
  a_ready_drops: assert property (s_write_taken |=> !awready_o && !wready_o)
    else $error("write readies stayed high after handshake");
  a_bresp_holds: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped before bready");
  a_rdata_holds: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data dropped before rready");
  a_upper_zero: assert property (rvalid_o |-> rdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_slverr_zero: assert property (rvalid_o && rresp_o == `GPP_RESP_SLVERR |-> rdata_o == 32'h0000_0000)
    else $error("refused read returned data");
  a_irq_gated: assert property (port7_pin_oe_o[7] [*4] |-> !ext_irq_line_four_o)
    else $error("interrupt line fed while pin drives");
  a_timer_gated: assert property (port8_pin_oe_o[0] [*4] |-> !timer_in_02_o)
    else $error("timer input fed while pin drives");
  a_input_follows: assert property ((settled && !port7_pin_oe_o[0] && port7_pin_i[0]) [*4] |-> timer_in_00_o)
    else $error("timer input missed high input pin");
endmodule // gpport_assertions

bind gpport_top gpport_assertions i_chk (.clk_i(clk_i), .resetn_i(resetn_i), .awvalid_i(awvalid_i),
  .awready_o(awready_o), .wvalid_i(wvalid_i), .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
  .bready_i(bready_i), .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
  .rvalid_o(rvalid_o), .rready_i(rready_i), .port7_pin_i(port7_pin_i), .port7_pin_oe_o(port7_pin_oe_o),
  .port8_pin_oe_o(port8_pin_oe_o), .ext_irq_line_four_o(ext_irq_line_four_o),
  .timer_in_00_o(timer_in_00_o), .timer_in_02_o(timer_in_02_o));

//--- tb/gpport_pin_model.sv
// pads outside the block: a driven pin shows the block's level
// assumes: bench supplies the outside level of every undriven pin
`timescale 1ns/100ps
module gpport_pin_model (
  // block side
  input  wire logic [7:0] p7_oe_i,
  input  wire logic [7:0] p7_drv_i,
  input  wire logic [1:0] p8_oe_i,
  input  wire logic [1:0] p8_drv_i,
  // outside world
  input  wire logic [7:0] p7_ext_i,
  input  wire logic [1:0] p8_ext_i,
  // resolved pad levels
  output logic      [7:0] p7_pin_o,
  output logic      [1:0] p8_pin_o
);
  // no contention model: the block wins wherever it drives
  assign p7_pin_o = (p7_oe_i & p7_drv_i) | (~p7_oe_i & p7_ext_i);
  assign p8_pin_o = (p8_oe_i & p8_drv_i) | (~p8_oe_i & p8_ext_i);
endmodule // gpport_pin_model

//--- tb/gpio_ports_seven_eight_tb.sv
// self-checking bench for the gpio port top
// assumes: design, map header and pin model compiled first
`timescale 1ns/100ps
`include "gpport_map.svh"
module gpio_ports_seven_eight_tb;
  logic        clk_i = 0, resetn_i = 0;
  logic [13:0] awaddr_i = '0, araddr_i = '0;
  logic [31:0] wdata_i = '0, rdata_o, rd;
  logic [3:0]  wstrb_i = 4'hf;
  logic        awvalid_i = 0, wvalid_i = 0, bready_i = 0, arvalid_i = 0, rready_i = 0;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0]  bresp_o, rresp_o, rs, p8_in, p8_o, p8_oe, p8_ext = '0;
  logic [7:0]  p7_in, p7_o, p7_oe, p7_ext = '0;
  logic [6:0]  periph = '0;
  logic [8:0]  to_periph;
  int          miscompares = 0, n_checks = 0;
  logic [11:0] r_idx [6] = '{`GPP_IDX_P7_LATCH, `GPP_IDX_P8_LATCH, `GPP_IDX_P7_DIR,
                             `GPP_IDX_P8_DIR, `GPP_IDX_P7_FSEL, `GPP_IDX_P8_FSEL};
  logic [7:0]  r_wr  [6] = '{8'ha5, 8'hff, 8'h96, 8'hff, 8'hff, 8'hff};
  logic [7:0]  r_exp [6] = '{8'ha5, 8'h03, 8'h96, 8'h03, 8'h1f, 8'h03};

  always #12.5 clk_i = ~clk_i;

  gpport_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
    .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
    .port7_pin_i(p7_in), .port7_pin_o(p7_o), .port7_pin_oe_o(p7_oe), .port8_pin_i(p8_in),
    .port8_pin_o(p8_o), .port8_pin_oe_o(p8_oe), .divider_out_i(periph[6]), .pulse_gen_a_out_1_i(periph[5]),
    .pulse_gen_a_out_0_i(periph[4]), .timer_out_01_i(periph[3]), .timer_out_00_i(periph[2]),
    .timer_out_03_i(periph[1]), .timer_out_02_i(periph[0]), .ext_irq_line_four_o(to_periph[8]),
    .ext_irq_line_three_o(to_periph[7]), .ext_irq_line_two_o(to_periph[6]), .timer_a_in_1_o(to_periph[5]),
    .timer_a_in_0_o(to_periph[4]), .timer_in_01_o(to_periph[3]), .timer_in_00_o(to_periph[2]),
    .timer_in_03_o(to_periph[1]), .timer_in_02_o(to_periph[0]));

  gpport_pin_model i_pins (.p7_oe_i(p7_oe), .p7_drv_i(p7_o), .p8_oe_i(p8_oe), .p8_drv_i(p8_o),
    .p7_ext_i(p7_ext), .p8_ext_i(p8_ext), .p7_pin_o(p7_in), .p8_pin_o(p8_in));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ****
  // bus master: valid held until its own ready edge
  // ****
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk_i);
    awaddr_i  <= {idx, 2'b00};
    wdata_i   <= {24'h00_0000, d};
    awvalid_i <= 1'b1;
    wvalid_i  <= 1'b1;
    bready_i  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awvalid_i && awready_o) awvalid_i <= 1'b0;
      if (wvalid_i && wready_o) wvalid_i <= 1'b0;
    end while (!bvalid_o);
    r = bresp_o;
    bready_i <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_i  <= {idx, 2'b00};
    arvalid_i <= 1'b1;
    rready_i  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arvalid_i && arready_o) arvalid_i <= 1'b0;
    end while (!rvalid_o);
    d = rdata_o;
    r = rresp_o;
    rready_i <= 1'b0;
  endtask

  task automatic rc(input logic [11:0] idx, input logic [7:0] exp);
    rdr(idx, rd, rs);
    chk("read resp", {30'h0, rs}, {30'h0, `GPP_RESP_OKAY});
    chk("read data", rd, {24'h00_0000, exp});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    p7_ext   <= 8'h3d;
    p8_ext   <= 2'b10;
    for (int i = 0; i < 6; i++) rc(r_idx[i], 8'h00);
    rc(`GPP_IDX_P7_PIN, 8'h3d);
    rc(`GPP_IDX_P8_PIN, 8'h02);
    chk("peripheral inputs", to_periph, 9'h076);
    $display("test reset values done");
    // ****
    // table: write then read back each of the six writable registers
    // ****
    for (int i = 0; i < 6; i++) begin
      wr(r_idx[i], r_wr[i], rs);
      chk("write resp", {30'h0, rs}, {30'h0, `GPP_RESP_OKAY});
      rc(r_idx[i], r_exp[i]);
    end
    $display("test register table done");
    periph <= 7'h59;
    repeat (4) @(posedge clk_i);
    chk("p7 enables", p7_oe, 8'h96);
    chk("p7 alternate drive", p7_o & p7_oe, 8'h96);
    chk("p8 enables", p8_oe, 2'b11);
    chk("p8 alternate drive", p8_o, 2'b01);
    rc(`GPP_IDX_P7_PIN, 8'h29);
    rc(`GPP_IDX_P8_PIN, 8'h00);
    chk("gated inputs", to_periph, 9'h064);
    wr(`GPP_IDX_P7_FSEL, 8'h00, rs);
    wr(`GPP_IDX_P8_FSEL, 8'h00, rs);
    repeat (2) @(posedge clk_i);
    chk("p7 latch drive", p7_o & p7_oe, 8'h84);
    chk("p8 latch drive", p8_o, 2'b11);
    $display("test pin drive done");
    // ****
    // awkward cases: reset mid-run, refused and read-only writes
    // ****
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    chk("enables after reset", {p7_oe, p8_oe}, 10'h000);
    rc(`GPP_IDX_P7_LATCH, 8'h00);
    wr(12'h100, 8'hff, rs);
    chk("unmapped write resp", {30'h0, rs}, {30'h0, `GPP_RESP_SLVERR});
    rdr(12'h100, rd, rs);
    chk("unmapped read resp", {30'h0, rs}, {30'h0, `GPP_RESP_SLVERR});
    chk("unmapped read data", rd, 32'h0000_0000);
    wr(`GPP_IDX_P7_PIN, 8'h00, rs);
    chk("read-only write resp", {30'h0, rs}, {30'h0, `GPP_RESP_OKAY});
    rc(`GPP_IDX_P7_PIN, 8'h3d);
    $display("test awkward cases done");
    give_verdict();
  end
endmodule // gpio_ports_seven_eight_tb
